/* File: hw/fhcs_params.svh */
// constants for the floppy host command/status port
// Functional notes
// [R1] decode 3-bit function code into the eight documented functions
// [R2] command bit 7 picks drive 0 or drive 1
// [R3] command bit 5 picks 12-bit (0) or 8-bit (1) transfers
// [R4] command bit 3 gives single (0) or double (1) density
// [R5] interface comes out of initialize in 12-bit mode
// [R6] load command with AC4 set/clear sets/clears maintenance; initialize clears
// [R7] maintenance stops run strobe and forces transfers into accumulator
// [R8] maintenance forces skip flags set; they stay set afterwards
// [R9] interrupt enable follows AC11 on enable op; irq is done and enable
// [R10] initialize clears skip flags and interrupt enable
// [R11] later maintenance loads make the register read back reliably
// [R12] host initializes after on-line maintenance, uses it for register only
// [R13] track 0..76 taken from low bits, high four bits ignored
// [R14] sector 1..26 taken from low bits, only inside a function
// [R15] data transfers are 8 or 12 bits per captured word length
// [R16] status word lands in register at function end and on read status
// [R17] status bit 11 flags data crc failure
// [R18] status bit 9 is init complete, hidden from read status
// [R19] status bit 8 always set, bit 10 reserved zero
// [R20] density mismatch sets bit 7, terminates with error and done
// [R21] status bit 6 shows media density of selected drive
// [R22] status bit 5 on deleted mark read or any write deleted
// [R23] status bit 4 shows selected drive ready
`ifndef FHCS_PARAMS_SVH
`define FHCS_PARAMS_SVH
// bit positions are lsb indices; numbering in the docs runs msb first
`define FHCS_W 12
`define FHCS_CMD_FN_HI 3
`define FHCS_CMD_FN_LO 1
`define FHCS_CMD_DEN 8
`define FHCS_CMD_MAINT 7
`define FHCS_CMD_W8 6
`define FHCS_CMD_DRV 4
`define FHCS_AC_IE 0
`define FHCS_ST_CRC 0
`define FHCS_ST_RSV 1
`define FHCS_ST_INIT 2
`define FHCS_ST_GEN2 3
`define FHCS_ST_DENERR 4
`define FHCS_ST_DRVDEN 5
`define FHCS_ST_DDM 6
`define FHCS_ST_RDY 7
`define FHCS_ADDR_W 8
`define FHCS_TRACK_MAX 8'h4c
`define FHCS_SECT_MIN 8'h01
`define FHCS_SECT_MAX 8'h1a
`define FHCS_BYTE_MASK 12'h0ff
`define FHCS_ZERO12 12'h000
`endif

/* File: hw/fhcs_pkg.sv */
// types for the floppy host command/status port
package fhcs_pkg;
	typedef enum logic [2:0] {
		FN_FILL = 3'b000,
		FN_EMPTY = 3'b001,
		FN_WRITE = 3'b010,
		FN_READ = 3'b011,
		FN_SET_DEN = 3'b100,
		FN_STATUS = 3'b101,
		FN_WRITE_DEL = 3'b110,
		FN_READ_ERR = 3'b111
	} fhcs_func_t;

	// io transfer instruction low digit
	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_LOAD_CMD = 3'b001,
		OP_XFER = 3'b010,
		OP_SKIP_TR = 3'b011,
		OP_SKIP_ERR = 3'b100,
		OP_SKIP_DONE = 3'b101,
		OP_INT_EN = 3'b110,
		OP_INIT = 3'b111
	} fhcs_op_t;

	// which word the controller expects on the next host transfer
	typedef enum logic [1:0] {
		PH_DATA = 2'b00,
		PH_TRACK = 2'b01,
		PH_SECTOR = 2'b10,
		PH_NONE = 2'b11
	} fhcs_phase_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} fhcs_state_t;

	typedef struct packed {
		fhcs_func_t func;
		logic drive_select;
		logic word8;
		logic density_select;
	} fhcs_cmd_t;

	typedef struct packed {
		logic crc_err;
		logic deleted_data_mark;
		logic init_complete_flag;
		logic [1:0] drive_media_density;
		logic [1:0] drive_ready_flag;
	} fhcs_stat_t;
endpackage

/* File: hw/fhcs_top.sv */
// host-side command, status and flag logic of the floppy interface
`timescale 1ns/1ps
`include "fhcs_params.svh"
module fhcs_top (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic iot_valid_i,
	input wire fhcs_pkg::fhcs_op_t iot_op_i,
	input wire logic [11:0] host_accumulator_i,
	input wire logic ctl_tr_i,
	input wire logic ctl_wr_i,
	input wire logic [11:0] ctl_wdata_i,
	input wire logic ctl_done_i,
	input wire logic ctl_err_i,
	input wire fhcs_pkg::fhcs_phase_t ctl_phase_i,
	input wire fhcs_pkg::fhcs_stat_t ctl_stat_i,
	output logic [11:0] acc_data_o,
	output logic acc_jam_o,
	output logic acc_or_o,
	output logic skip_o,
	output logic irq_o,
	output logic run_o,
	output logic init_o,
	output fhcs_pkg::fhcs_cmd_t cmd_o,
	output logic [7:0] track_o,
	output logic [7:0] sector_o,
	output logic addr_err_o,
	output logic [11:0] data_o,
	output logic data_valid_o,
	output logic maint_o
);
	fhcs_pkg::fhcs_state_t state_r;
	fhcs_pkg::fhcs_cmd_t cmd_r;
	logic [11:0] iface_r;
	logic maint_r, ie_r, tr_r, err_r, done_r, density_mismatch_error_r;
	logic op_ld, op_xfer, op_str, op_ser, op_sdn, op_ie, init_any, ld_new, den_mis;
	logic den_post_r;
	logic [11:0] den_word;

	// masks a word to the active transfer width
	function automatic logic [11:0] fit_word(input logic [11:0] w, input logic w8);
		fit_word = w8 ? (w & `FHCS_BYTE_MASK) : w;
	endfunction

	// instruction strobes
	assign op_ld = iot_valid_i && (iot_op_i == fhcs_pkg::OP_LOAD_CMD);
	assign op_xfer = iot_valid_i && (iot_op_i == fhcs_pkg::OP_XFER);
	assign op_str = iot_valid_i && (iot_op_i == fhcs_pkg::OP_SKIP_TR);
	assign op_ser = iot_valid_i && (iot_op_i == fhcs_pkg::OP_SKIP_ERR);
	assign op_sdn = iot_valid_i && (iot_op_i == fhcs_pkg::OP_SKIP_DONE);
	assign op_ie = iot_valid_i && (iot_op_i == fhcs_pkg::OP_INT_EN);
	assign init_any = srst_i || (iot_valid_i && (iot_op_i == fhcs_pkg::OP_INIT));
	// a new function only starts when the previous one has finished
	assign ld_new = op_ld && (state_r == fhcs_pkg::ST_IDLE)
		&& !host_accumulator_i[`FHCS_CMD_MAINT];

	// density-checked functions compare requested against media density
	always_comb begin
		den_mis = 1'b0;
		case (fhcs_pkg::fhcs_func_t'(host_accumulator_i[`FHCS_CMD_FN_HI:`FHCS_CMD_FN_LO]))
			fhcs_pkg::FN_WRITE, fhcs_pkg::FN_READ, fhcs_pkg::FN_WRITE_DEL: begin
				den_mis = host_accumulator_i[`FHCS_CMD_DEN]
					!= ctl_stat_i.drive_media_density[host_accumulator_i[`FHCS_CMD_DRV]];
			end
			default: begin
				den_mis = 1'b0;
			end
		endcase
	end

	// status word assembly at function end
	function automatic logic [11:0] status_word(input fhcs_pkg::fhcs_stat_t s,
		input fhcs_pkg::fhcs_cmd_t c, input logic derr);
		logic [11:0] w;
		w = `FHCS_ZERO12;
		w[`FHCS_ST_CRC] = s.crc_err; // [R17]
		w[`FHCS_ST_RSV] = 1'b0; // [R19]
		w[`FHCS_ST_INIT] = s.init_complete_flag && (c.func != fhcs_pkg::FN_STATUS); // [R18]
		w[`FHCS_ST_GEN2] = 1'b1; // [R19]
		w[`FHCS_ST_DENERR] = derr; // [R20]
		w[`FHCS_ST_DRVDEN] = s.drive_media_density[c.drive_select]; // [R21]
		w[`FHCS_ST_DDM] = s.deleted_data_mark || (c.func == fhcs_pkg::FN_WRITE_DEL); // [R22]
		w[`FHCS_ST_RDY] = s.drive_ready_flag[c.drive_select]; // [R23]
		status_word = w;
	endfunction

	// maintenance flip-flop
	always_ff @(posedge mclk_i) begin
		if (init_any) begin
			maint_r <= 1'b0; // [R6]
		end else if (op_ld) begin
			maint_r <= host_accumulator_i[`FHCS_CMD_MAINT]; // [R6]
		end
	end

	// command capture; reset leaves 12-bit mode
	always_ff @(posedge mclk_i) begin
		if (init_any) begin
			cmd_r <= '0; // [R5]
		end else if (ld_new) begin
			cmd_r.func <= fhcs_pkg::fhcs_func_t'(
				host_accumulator_i[`FHCS_CMD_FN_HI:`FHCS_CMD_FN_LO]); // [R1]
			cmd_r.drive_select <= host_accumulator_i[`FHCS_CMD_DRV]; // [R2]
			cmd_r.word8 <= host_accumulator_i[`FHCS_CMD_W8]; // [R3]
			cmd_r.density_select <= host_accumulator_i[`FHCS_CMD_DEN]; // [R4]
		end
	end

	// function sequencing
	always_ff @(posedge mclk_i) begin
		if (init_any) begin
			state_r <= fhcs_pkg::ST_IDLE;
			density_mismatch_error_r <= 1'b0;
		end else begin
			case (state_r)
				fhcs_pkg::ST_IDLE: begin
					if (ld_new && !den_mis) begin
						state_r <= fhcs_pkg::ST_BUSY;
						density_mismatch_error_r <= 1'b0;
					end else if (ld_new) begin
						density_mismatch_error_r <= 1'b1; // [R20]
					end
				end
				fhcs_pkg::ST_BUSY: begin
					if (ctl_done_i) begin
						state_r <= fhcs_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= fhcs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// interface register: host loads, controller loads, status at completion
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			iface_r <= `FHCS_ZERO12;
		end else if (op_ld) begin
			iface_r <= host_accumulator_i; // [R11]
		end else if (den_post_r) begin
			iface_r <= den_word; // [R20]
		end else if (state_r == fhcs_pkg::ST_BUSY && ctl_done_i) begin
			iface_r <= status_word(ctl_stat_i, cmd_r, 1'b0); // [R16]
		end else if (ctl_wr_i && !maint_r) begin
			iface_r <= fit_word(ctl_wdata_i, cmd_r.word8); // [R15]
		end else if (op_xfer && !maint_r && ctl_phase_i != fhcs_pkg::PH_NONE) begin
			iface_r <= fit_word(host_accumulator_i, cmd_r.word8); // [R15]
		end
	end

	// mismatch status is placed one cycle after the refused load
	always_ff @(posedge mclk_i) begin
		if (init_any) begin
			den_post_r <= 1'b0;
		end else begin
			den_post_r <= ld_new && den_mis;
		end
	end

	// skip flags: set wins over a skip clear, maintenance holds them set
	always_ff @(posedge mclk_i) begin
		if (init_any) begin
			tr_r <= 1'b0; // [R10]
			err_r <= 1'b0; // [R10]
			done_r <= 1'b0; // [R10]
		end else if (maint_r) begin
			tr_r <= 1'b1; // [R8]
			err_r <= 1'b1; // [R8]
			done_r <= 1'b1; // [R8]
		end else begin
			tr_r <= ctl_tr_i || (tr_r && !op_str);
			err_r <= (ctl_err_i && state_r == fhcs_pkg::ST_BUSY) || (ld_new && den_mis)
				|| (err_r && !op_ser); // [R20]
			done_r <= (ctl_done_i && state_r == fhcs_pkg::ST_BUSY) || (ld_new && den_mis)
				|| (done_r && !op_sdn && !ld_new); // [R20]
		end
	end

	// interrupt enable
	always_ff @(posedge mclk_i) begin
		if (init_any) begin
			ie_r <= 1'b0; // [R10]
		end else if (op_ie) begin
			ie_r <= host_accumulator_i[`FHCS_AC_IE]; // [R9]
		end
	end

	// host-facing answers, all registered
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			acc_data_o <= `FHCS_ZERO12;
			acc_jam_o <= 1'b0;
			acc_or_o <= 1'b0;
			skip_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			acc_jam_o <= op_ld || (op_xfer && (maint_r || !cmd_r.word8)
				&& (maint_r || done_r || ctl_phase_i == fhcs_pkg::PH_NONE));
			acc_or_o <= op_xfer && !maint_r && cmd_r.word8
				&& (done_r || ctl_phase_i == fhcs_pkg::PH_NONE);
			// load command clears the accumulator; maintenance reads whole register
			acc_data_o <= op_ld ? `FHCS_ZERO12
				: (maint_r ? iface_r : fit_word(iface_r, cmd_r.word8)); // [R7]
			skip_o <= (op_str && tr_r) || (op_ser && err_r) || (op_sdn && done_r);
			irq_o <= done_r && ie_r; // [R9]
		end
	end

	// controller-facing strobes and captured words
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			run_o <= 1'b0;
			init_o <= 1'b1;
			track_o <= 8'h00;
			sector_o <= 8'h00;
			addr_err_o <= 1'b0;
			data_o <= `FHCS_ZERO12;
			data_valid_o <= 1'b0;
		end else begin
			init_o <= init_any;
			// run is withheld from transfers in maintenance so the controller never sees them
			run_o <= (ld_new && !den_mis) || (op_xfer && !maint_r
				&& state_r == fhcs_pkg::ST_BUSY); // [R7]
			data_valid_o <= op_xfer && !maint_r && ctl_phase_i == fhcs_pkg::PH_DATA
				&& state_r == fhcs_pkg::ST_BUSY;
			data_o <= fit_word(host_accumulator_i, cmd_r.word8); // [R15]
			if (op_xfer && !maint_r && state_r == fhcs_pkg::ST_BUSY) begin
				if (ctl_phase_i == fhcs_pkg::PH_TRACK) begin
					track_o <= host_accumulator_i[`FHCS_ADDR_W-1:0]; // [R13]
					addr_err_o <= host_accumulator_i[`FHCS_ADDR_W-1:0] > `FHCS_TRACK_MAX; // [R13]
				end else if (ctl_phase_i == fhcs_pkg::PH_SECTOR) begin
					sector_o <= host_accumulator_i[`FHCS_ADDR_W-1:0]; // [R14]
					addr_err_o <= host_accumulator_i[`FHCS_ADDR_W-1:0] < `FHCS_SECT_MIN
						|| host_accumulator_i[`FHCS_ADDR_W-1:0] > `FHCS_SECT_MAX; // [R14]
				end
			end
		end
	end

	// state views for the controller
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cmd_o <= '0;
			maint_o <= 1'b0;
		end else begin
			cmd_o <= cmd_r;
			maint_o <= maint_r;
		end
	end

	// mismatch status word must land even though no function ran
	assign den_word = status_word(ctl_stat_i, cmd_r, density_mismatch_error_r);

	// maintenance sets every skip flag one cycle after it is set
	a_maint_flags: assert property (@(posedge mclk_i) disable iff (srst_i)
		maint_r && !init_any |=> tr_r && err_r && done_r) // [R8]
		else $error("maintenance did not force skip flags");

	// done and transfer flags are still set in the cycle maintenance ends
	a_flags_persist: assert property (@(posedge mclk_i) disable iff (srst_i)
		$fell(maint_r) && !$past(init_any) && !init_any |-> done_r && tr_r) // [R8]
		else $error("skip flags lost on leaving maintenance");

	// initialize clears all flags and interrupt enable
	a_init_clears: assert property (@(posedge mclk_i)
		iot_valid_i && iot_op_i == fhcs_pkg::OP_INIT |=> !tr_r && !err_r && !done_r && !ie_r) // [R10]
		else $error("initialize left a flag set");

	// interrupt follows done and enable with one cycle
	a_irq_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
		##1 irq_o == $past(done_r && ie_r)) // [R9]
		else $error("irq does not follow done and enable");

	// no run strobe on a transfer while maintenance is set
	a_no_run_maint: assert property (@(posedge mclk_i) disable iff (srst_i)
		op_xfer && maint_r |=> !run_o) // [R7]
		else $error("run strobe during maintenance");

	// maintenance transfer returns the register loaded earlier
	a_maint_readback: assert property (@(posedge mclk_i) disable iff (srst_i)
		op_ld && maint_r && host_accumulator_i[`FHCS_CMD_MAINT] ##1 (!op_ld)[*4]
		##1 (op_xfer && maint_r)
		|=> acc_jam_o && acc_data_o == $past(host_accumulator_i, 6)) // [R11]
		else $error("maintenance readback mismatch");

	// completion places a status word with bit 8 set and bit 10 clear
	a_status_land: assert property (@(posedge mclk_i) disable iff (srst_i)
		state_r == fhcs_pkg::ST_BUSY && ctl_done_i && !op_ld && !init_any
		|=> iface_r[`FHCS_ST_GEN2] && !iface_r[`FHCS_ST_RSV] && done_r) // [R16]
		else $error("status word not placed at completion");

	// density mismatch ends with error and done at once
	a_den_mismatch: assert property (@(posedge mclk_i) disable iff (srst_i)
		ld_new && den_mis && !maint_r |=> err_r && done_r && state_r == fhcs_pkg::ST_IDLE) // [R20]
		else $error("density mismatch not terminated");

	// reset comes out in 12-bit mode
	a_reset_w12: assert property (@(posedge mclk_i)
		srst_i |=> !cmd_r.word8) // [R5]
		else $error("not in 12-bit mode after initialize");

	// an out-of-range track is flagged
	a_track_range: assert property (@(posedge mclk_i) disable iff (srst_i)
		op_xfer && !maint_r && state_r == fhcs_pkg::ST_BUSY && ctl_phase_i == fhcs_pkg::PH_TRACK
		&& host_accumulator_i[`FHCS_ADDR_W-1:0] > `FHCS_TRACK_MAX |=> addr_err_o) // [R13]
		else $error("illegal track not flagged");
endmodule

/* File: verif/fhcs_host_model.sv */
// host processor model: issues io instructions and keeps the accumulator
`timescale 1ns/1ps
module fhcs_host_model (
	input wire logic mclk_i,
	input wire logic [11:0] acc_data_i,
	input wire logic acc_jam_i,
	input wire logic acc_or_i,
	output logic iot_valid_o,
	output fhcs_pkg::fhcs_op_t iot_op_o,
	output logic [11:0] acc_o
);
	initial begin
		iot_valid_o = 1'b0;
		iot_op_o = fhcs_pkg::OP_NOP;
		acc_o = 12'h000;
	end
	// jam replaces the whole word; or touches only the low byte, upper four kept
	always @(posedge mclk_i) begin
		if (acc_jam_i) begin
			acc_o <= acc_data_i;
		end else if (acc_or_i) begin
			acc_o[7:0] <= acc_o[7:0] | acc_data_i[7:0];
		end
	end
	// one instruction per call, launched off the falling edge
	// a released bus shows nop, so a stale op never looks like a request
	task automatic io_transfer_instruction(input fhcs_pkg::fhcs_op_t op, input logic [11:0] ac);
		@(negedge mclk_i);
		acc_o = ac;
		iot_op_o = op;
		iot_valid_o = 1'b1;
		@(negedge mclk_i);
		iot_valid_o = 1'b0;
		iot_op_o = fhcs_pkg::OP_NOP;
	endtask
endmodule

/* File: verif/fhcs_top_tb_top.sv */
// self-checking bench for the floppy host command/status port
`timescale 1ns/1ps
`include "fhcs_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("Error at %0t: got %h want %h", $time, a, b); end end
module fhcs_top_tb_top;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic iot_valid, ctl_tr = 1'b0, ctl_wr = 1'b0, ctl_done = 1'b0, ctl_err = 1'b0;
	fhcs_pkg::fhcs_op_t iot_op;
	fhcs_pkg::fhcs_phase_t ctl_phase = fhcs_pkg::PH_NONE;
	fhcs_pkg::fhcs_stat_t ctl_stat = 7'h00;
	fhcs_pkg::fhcs_cmd_t cmd_o;
	logic [11:0] acc, acc_data_o, data_o, v, a, e;
	logic [11:0] ctl_wdata = 12'h000;
	logic acc_jam_o, acc_or_o, skip_o, irq_o, run_o, init_o, addr_err_o, data_valid_o, maint_o;
	logic [7:0] track_o, sector_o;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int tv[6] = '{0, 1, 26, 27, 76, 77};
	logic te[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	always #10 mclk_i = ~mclk_i;
	fhcs_host_model u_host (.mclk_i(mclk_i), .acc_data_i(acc_data_o), .acc_jam_i(acc_jam_o),
		.acc_or_i(acc_or_o), .iot_valid_o(iot_valid), .iot_op_o(iot_op), .acc_o(acc));
	fhcs_top u_fhcs_top (.mclk_i(mclk_i), .srst_i(srst_i), .iot_valid_i(iot_valid),
		.iot_op_i(iot_op), .host_accumulator_i(acc), .ctl_tr_i(ctl_tr), .ctl_wr_i(ctl_wr),
		.ctl_wdata_i(ctl_wdata), .ctl_done_i(ctl_done), .ctl_err_i(ctl_err),
		.ctl_phase_i(ctl_phase), .ctl_stat_i(ctl_stat), .acc_data_o(acc_data_o),
		.acc_jam_o(acc_jam_o), .acc_or_o(acc_or_o), .skip_o(skip_o), .irq_o(irq_o),
		.run_o(run_o), .init_o(init_o), .cmd_o(cmd_o), .track_o(track_o), .sector_o(sector_o),
		.addr_err_o(addr_err_o), .data_o(data_o), .data_valid_o(data_valid_o), .maint_o(maint_o));
	// status word as the host should see it after a function ends
	function automatic logic [11:0] exp_stat(fhcs_pkg::fhcs_stat_t s, logic d, logic [2:0] f);
		logic [11:0] r;
		r = 12'h000;
		r[`FHCS_ST_CRC] = s.crc_err;
		r[`FHCS_ST_INIT] = s.init_complete_flag & (f != fhcs_pkg::FN_STATUS);
		r[`FHCS_ST_GEN2] = 1'b1;
		r[`FHCS_ST_DRVDEN] = s.drive_media_density[d];
		r[`FHCS_ST_DDM] = s.deleted_data_mark | (f == fhcs_pkg::FN_WRITE_DEL);
		r[`FHCS_ST_RDY] = s.drive_ready_flag[d];
		return r;
	endfunction
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// load a command; the accumulator must come back cleared
	task automatic load(input logic [11:0] w);
		u_host.io_transfer_instruction(fhcs_pkg::OP_LOAD_CMD, w);
		`CHK(run_o, ~w[`FHCS_CMD_MAINT])
		tick(1);
		`CHK(acc, 12'h000)
		`CHK(maint_o, w[`FHCS_CMD_MAINT])
		if (!w[`FHCS_CMD_MAINT]) begin
			`CHK(cmd_o.func, w[`FHCS_CMD_FN_HI:`FHCS_CMD_FN_LO])
			`CHK(cmd_o.drive_select, w[`FHCS_CMD_DRV])
			`CHK(cmd_o.word8, w[`FHCS_CMD_W8])
			`CHK(cmd_o.density_select, w[`FHCS_CMD_DEN])
		end
	endtask
	task automatic xfer(input fhcs_pkg::fhcs_phase_t ph, input logic [11:0] w);
		ctl_phase = ph;
		u_host.io_transfer_instruction(fhcs_pkg::OP_XFER, w);
	endtask
	task automatic skip(input fhcs_pkg::fhcs_op_t op, input logic x);
		u_host.io_transfer_instruction(op, acc);
		`CHK(skip_o, x)
	endtask
	// controller ends a function, with or without error
	task automatic finish(input logic err);
		@(negedge mclk_i);
		ctl_done = 1'b1;
		ctl_err = err;
		ctl_phase = fhcs_pkg::PH_NONE;
		@(negedge mclk_i);
		ctl_done = 1'b0;
		ctl_err = 1'b0;
	endtask
	// a hung handshake must still end the run with a verdict
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(81620));
		tick(4);
		`CHK(init_o, 1'b1)
		srst_i = 1'b0;
		tick(1);
		`CHK(init_o, 1'b0)
		`CHK(cmd_o.word8, 1'b0)
		// every function code, random drive, width and density
		for (int i = 0; i < 8; i++) begin
			v = 12'($urandom) & 12'h150;
			v[`FHCS_CMD_FN_HI:`FHCS_CMD_FN_LO] = 3'(i);
			ctl_stat = fhcs_pkg::fhcs_stat_t'(7'($urandom));
			ctl_stat.drive_media_density = {2{v[`FHCS_CMD_DEN]}};
			ctl_stat.init_complete_flag = (i == 5);
			u_host.io_transfer_instruction(fhcs_pkg::OP_INT_EN, {11'h000, i[1]});
			load(v);
			a = 12'($urandom);
			xfer(fhcs_pkg::PH_DATA, a);
			`CHK(data_valid_o, 1'b1)
			`CHK(data_o, v[`FHCS_CMD_W8] ? (a & `FHCS_BYTE_MASK) : a)
			@(negedge mclk_i) ctl_tr = 1'b1;
			@(negedge mclk_i) ctl_tr = 1'b0;
			skip(fhcs_pkg::OP_SKIP_TR, 1'b1);
			skip(fhcs_pkg::OP_SKIP_TR, 1'b0);
			finish(i[0]);
			tick(1);
			`CHK(irq_o, i[1])
			skip(fhcs_pkg::OP_SKIP_ERR, i[0]);
			skip(fhcs_pkg::OP_SKIP_DONE, 1'b1);
			tick(1);
			`CHK(irq_o, 1'b0)
			a = 12'($urandom);
			xfer(fhcs_pkg::PH_NONE, a);
			tick(1);
			e = exp_stat(ctl_stat, v[`FHCS_CMD_DRV], 3'(i));
			`CHK(acc, v[`FHCS_CMD_W8] ? {a[11:8], a[7:0] | e[7:0]} : e)
		end
		// sector words at both ends of their range, track words at the top end, junk in the high four bits
		ctl_stat.drive_media_density = 2'b00;
		load(12'h006);
		for (int k = 0; k < 6; k++) begin
			v = {4'($urandom), 8'(tv[k])};
			xfer(k < 4 ? fhcs_pkg::PH_SECTOR : fhcs_pkg::PH_TRACK, v);
			if (k < 4) `CHK(sector_o, v[7:0])
			else `CHK(track_o, v[7:0])
			`CHK(addr_err_o, te[k])
		end
		finish(1'b0);
		skip(fhcs_pkg::OP_SKIP_DONE, 1'b1);
		// write sector asking double density on single density media is refused
		u_host.io_transfer_instruction(fhcs_pkg::OP_LOAD_CMD, 12'h104);
		`CHK(run_o, 1'b0)
		skip(fhcs_pkg::OP_SKIP_ERR, 1'b1);
		skip(fhcs_pkg::OP_SKIP_DONE, 1'b1);
		xfer(fhcs_pkg::PH_NONE, 12'h000);
		tick(1);
		`CHK(acc[`FHCS_ST_DENERR], 1'b1)
		`CHK(acc[`FHCS_ST_GEN2], 1'b1)
		// maintenance: register write and read back, flags forced
		u_host.io_transfer_instruction(fhcs_pkg::OP_INT_EN, 12'h001);
		load((12'($urandom) & 12'hfbf) | 12'h080);
		v = (12'($urandom) & 12'hfbf) | 12'h080;
		load(v);
		@(negedge mclk_i) {ctl_wr, ctl_wdata} = {1'b1, ~v};
		@(negedge mclk_i) ctl_wr = 1'b0;
		xfer(fhcs_pkg::PH_DATA, 12'h000);
		`CHK(run_o, 1'b0)
		`CHK(acc_jam_o, 1'b1)
		tick(1);
		`CHK(acc, v)
		`CHK(irq_o, 1'b1)
		for (int k = 0; k < 6; k++) begin
			skip(fhcs_pkg::fhcs_op_t'(3 + k % 3), 1'b1);
		end
		load(12'h000);
		for (int k = 3; k < 6; k++) begin
			skip(fhcs_pkg::fhcs_op_t'(k), 1'b1);
		end
		u_host.io_transfer_instruction(fhcs_pkg::OP_INIT, 12'h000);
		`CHK(init_o, 1'b1)
		for (int k = 3; k < 6; k++) begin
			skip(fhcs_pkg::fhcs_op_t'(k), 1'b0);
		end
		`CHK(irq_o, 1'b0)
		`CHK(maint_o, 1'b0)
		end_sim();
	end
endmodule
